// *** src/argen_consts.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the ramp generator
// Assumes: 32-bit APB data, one word per register
// Notes:   Definitions only
`ifndef ARGEN_CONSTS_SVH
`define ARGEN_CONSTS_SVH

// Timing
`define ARGEN_CLK_MHZ        125
`define ARGEN_TICK_MS        100
`define ARGEN_TICK_CYC       (`ARGEN_TICK_MS * 1000 * `ARGEN_CLK_MHZ)
`define ARGEN_RATE_DIV       10

// Register byte offsets
`define ARGEN_OFS_OFFSET     8'h00
`define ARGEN_OFS_SS_OFS     8'h04
`define ARGEN_OFS_LVL1       8'h08
`define ARGEN_OFS_LVL2       8'h0C
`define ARGEN_OFS_MAX_LEVEL_LIMIT       8'h10
`define ARGEN_OFS_RATE       8'h14
`define ARGEN_OFS_GAIN       8'h18
`define ARGEN_OFS_LEVEL      8'h1C
`define ARGEN_OFS_STATUS     8'h20

// Field layout of the status word
`define ARGEN_STAT_SCALED_LSB 0
`define ARGEN_STAT_STATE_LSB  16

// Reset values and scaled-output ceiling
`define ARGEN_RST_LVL        18'h0_0000
`define ARGEN_RST_MAX_LEVEL_LIMIT       18'h0_4E20
`define ARGEN_RST_RATE       14'h000A
`define ARGEN_RST_GAIN       16'h0001
`define ARGEN_SCALED_MAX     19'h0_7FFF

`endif

// *** src/argen_pkg.sv ***
// Purpose: Types shared by the ramp generator modules
// Assumes: Levels fit an 18-bit signed word
// Notes:   Constants live in argen_consts.svh
package argen_pkg;

   typedef logic signed [17:0] argen_lvl_t;
   typedef logic [31:0]        argen_cnt_t;

   typedef enum logic [2:0] {
      ARGEN_IDLE       = 3'b000,
      ARGEN_START_HOLD = 3'b001,
      ARGEN_RUN        = 3'b010,
      ARGEN_DECEL      = 3'b011,
      ARGEN_STOP_HOLD  = 3'b100,
      ARGEN_LOCKED     = 3'b101
   } argen_state_e;

   typedef struct packed {
      argen_state_e state;
      argen_lvl_t   level;
      argen_lvl_t   offset;
      argen_lvl_t   ss_ofs;
      argen_lvl_t   lvl1;
      argen_lvl_t   lvl2;
      argen_lvl_t   max_level_limit;
      logic [13:0]  rate;
      logic [15:0]  gain;
      logic         en_q;
      logic         st_q;
      logic [15:0]  scaled;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
   } argen_regs_s;

   typedef struct packed {
      argen_cnt_t cnt;
      logic       tick;
   } argen_tick_s;

endpackage : argen_pkg

// *** src/argen_step.sv ***
// Purpose: One ramp step of a level toward a goal
// Assumes: Step is positive
// Notes:   Never overshoots the goal
`timescale 1ns/1ps
module argen_step #(
   parameter int LW = 18
) (
   // Operands
   input  wire logic signed [LW-1:0] cur,
   input  wire logic signed [LW-1:0] goal,
   input  wire logic        [LW-1:0] step,
   // Result
   output logic signed      [LW-1:0] nxt
);

   logic signed [LW:0] up;
   logic signed [LW:0] dn;
   logic signed [LW:0] goal_x;

   always_comb begin
      goal_x = {goal[LW-1], goal};
      up     = {cur[LW-1], cur} + $signed({1'b0, step});
      dn     = {cur[LW-1], cur} - $signed({1'b0, step});
      if (cur < goal) begin
         nxt = (up > goal_x) ? goal : up[LW-1:0];
      end else if (cur > goal) begin
         nxt = (dn < goal_x) ? goal : dn[LW-1:0];
      end else begin
         nxt = cur;
      end
   end

endmodule : argen_step

// *** src/argen_tick.sv ***
// Purpose: Prescaler giving one-cycle update ticks
// Assumes: TICK_CYCLES of at least 2
// Notes:   Clear restarts a full period, used for the hold intervals
`timescale 1ns/1ps
module argen_tick #(
   parameter int unsigned TICK_CYCLES = 12500000
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic clk_en,
   // Control
   input  wire logic clear,
   output logic      tick
);

   argen_pkg::argen_tick_s q;
   argen_pkg::argen_tick_s d;

   always_comb begin
      d      = q;
      d.tick = 1'b0;
      if (clear) begin
         d.cnt = '0;
      end else if (q.cnt == 32'(TICK_CYCLES - 1)) begin
         d.cnt  = '0;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign tick = q.tick;

endmodule : argen_tick

// *** src/argen_top.sv ***
// Purpose: Analogue ramp generator with APB parameter registers
// Assumes: Control inputs come from logic on ref_clk
// Notes:   Level advances once per update tick
`timescale 1ns/1ps
`include "argen_consts.svh"
module argen_top #(
   parameter int unsigned TICK_CYCLES = `ARGEN_TICK_CYC
) (
   // Clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   // Function block inputs
   input  wire logic        enable,
   input  wire logic        level_select,
   input  wire logic        decel_stop_request,
   // Function block outputs
   output logic [15:0]      scaled_output,
   output logic [17:0]      current_level,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);

   argen_pkg::argen_regs_s q;
   argen_pkg::argen_regs_s d;
   argen_pkg::argen_lvl_t  ss_level;
   argen_pkg::argen_lvl_t  goal_sel;
   argen_pkg::argen_lvl_t  goal_run;
   argen_pkg::argen_lvl_t  nxt_run;
   argen_pkg::argen_lvl_t  nxt_dec;
   logic [17:0]            step;
   logic [13:0]            rate_div;
   logic                   tick;
   logic                   tick_clr;
   logic                   rise_en;
   logic                   fall_en;
   logic                   rise_st;
   logic signed [18:0]     diff;
   logic signed [18:0]     quo;
   logic                   setup;
   logic                   access;
   logic                   mapped;
   logic [31:0]            rd_word;

   // Update tick, restarted at each hold
   argen_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .clear   (tick_clr),
      .tick    (tick)
   );

   argen_step #(.LW(18)) u_step_run (
      .cur  (q.level),
      .goal (goal_run),
      .step (step),
      .nxt  (nxt_run)
   );

   argen_step #(.LW(18)) u_step_dec (
      .cur  (q.level),
      .goal (ss_level),
      .step (step),
      .nxt  (nxt_dec)
   );

   always_comb begin
      ss_level = q.offset + q.ss_ofs;
      goal_sel = level_select ? q.lvl2 : q.lvl1;
      goal_run = ($signed(goal_sel) > $signed(q.max_level_limit)) ? q.max_level_limit : goal_sel;
      rate_div = q.rate / 14'(`ARGEN_RATE_DIV);
      // Slow rates would never move otherwise
      step     = (rate_div == 14'h0000) ? 18'h0_0001 : {4'h0, rate_div};
      rise_en  = enable & ~q.en_q;
      fall_en  = ~enable & q.en_q;
      rise_st  = decel_stop_request & ~q.st_q;
   end

   always_comb begin
      d         = q;
      tick_clr  = 1'b0;
      d.en_q    = enable;
      d.st_q    = decel_stop_request;
      d.pready  = 1'b0;
      d.pslverr = 1'b0;

      unique case (q.state)
         argen_pkg::ARGEN_IDLE: begin
            if (rise_en) begin
               d.level  = ss_level;
               d.state  = argen_pkg::ARGEN_START_HOLD;
               tick_clr = 1'b1;
            end
         end
         argen_pkg::ARGEN_START_HOLD: begin
            if (tick) begin
               d.state = argen_pkg::ARGEN_RUN;
            end
         end
         argen_pkg::ARGEN_RUN: begin
            // Stepping from the present level keeps select changes smooth
            if (tick) begin
               d.level = nxt_run;
            end
         end
         argen_pkg::ARGEN_DECEL: begin
            if (tick) begin
               d.level = nxt_dec;
               if (nxt_dec == ss_level) begin
                  d.state  = argen_pkg::ARGEN_STOP_HOLD;
                  tick_clr = 1'b1;
               end
            end
         end
         argen_pkg::ARGEN_STOP_HOLD: begin
            if (tick) begin
               d.level = q.offset;
               d.state = argen_pkg::ARGEN_LOCKED;
            end
         end
         argen_pkg::ARGEN_LOCKED: begin
            if (!enable && !decel_stop_request) begin
               d.state = argen_pkg::ARGEN_IDLE;
            end
         end
         default: begin
            d.state = argen_pkg::ARGEN_IDLE;
            d.level = q.offset;
         end
      endcase

      if (rise_st && (q.state == argen_pkg::ARGEN_START_HOLD || q.state == argen_pkg::ARGEN_RUN)) begin
         d.state = argen_pkg::ARGEN_DECEL;
      end

      // Disable wins over any ramp activity
      if (fall_en) begin
         d.level = q.offset;
         if (decel_stop_request && (q.state == argen_pkg::ARGEN_DECEL ||
             q.state == argen_pkg::ARGEN_STOP_HOLD || q.state == argen_pkg::ARGEN_LOCKED)) begin
            d.state = argen_pkg::ARGEN_LOCKED;
         end else begin
            d.state = argen_pkg::ARGEN_IDLE;
         end
         tick_clr = 1'b0;
      end

      if ($signed(d.level) > $signed(q.max_level_limit)) begin
         d.level = q.max_level_limit;
      end

      // Scaled output lags the level by one cycle
      diff = {q.level[17], q.level} - {q.offset[17], q.offset};
      quo  = (q.gain == 16'h0000) ? diff : diff / $signed({3'b000, q.gain});
      if (quo < 0) begin
         d.scaled = 16'h0000;
      end else if (quo > $signed(`ARGEN_SCALED_MAX)) begin
         d.scaled = 16'h7FFF;
      end else begin
         d.scaled = quo[15:0];
      end

      // APB: answer in the first access cycle
      setup  = psel & ~penable;
      access = psel & penable & q.pready;
      mapped = 1'b1;
      unique case (paddr)
         `ARGEN_OFS_OFFSET: rd_word = 32'(q.offset);
         `ARGEN_OFS_SS_OFS: rd_word = 32'(q.ss_ofs);
         `ARGEN_OFS_LVL1:   rd_word = 32'(q.lvl1);
         `ARGEN_OFS_LVL2:   rd_word = 32'(q.lvl2);
         `ARGEN_OFS_MAX_LEVEL_LIMIT:   rd_word = 32'(q.max_level_limit);
         `ARGEN_OFS_RATE:   rd_word = {18'h0_0000, q.rate};
         `ARGEN_OFS_GAIN:   rd_word = {16'h0000, q.gain};
         `ARGEN_OFS_LEVEL:  rd_word = 32'(q.level);
         `ARGEN_OFS_STATUS: rd_word = (32'(q.state) << `ARGEN_STAT_STATE_LSB) |
                                      (32'(q.scaled) << `ARGEN_STAT_SCALED_LSB);
         default: begin
            rd_word = 32'h0000_0000;
            mapped  = 1'b0;
         end
      endcase
      if (setup) begin
         d.pready  = 1'b1;
         d.pslverr = ~mapped;
         d.prdata  = pwrite ? 32'h0000_0000 : rd_word;
      end
      if (access && pwrite && !q.pslverr) begin
         unique case (paddr)
            `ARGEN_OFS_OFFSET: d.offset = pwdata[17:0];
            `ARGEN_OFS_SS_OFS: d.ss_ofs = pwdata[17:0];
            `ARGEN_OFS_LVL1:   d.lvl1   = pwdata[17:0];
            `ARGEN_OFS_LVL2:   d.lvl2   = pwdata[17:0];
            `ARGEN_OFS_MAX_LEVEL_LIMIT:   d.max_level_limit   = pwdata[17:0];
            `ARGEN_OFS_RATE:   d.rate   = pwdata[13:0];
            `ARGEN_OFS_GAIN:   d.gain   = pwdata[15:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '{state:   argen_pkg::ARGEN_IDLE,
                level:   `ARGEN_RST_LVL,
                offset:  `ARGEN_RST_LVL,
                ss_ofs:  `ARGEN_RST_LVL,
                lvl1:    `ARGEN_RST_LVL,
                lvl2:    `ARGEN_RST_LVL,
                max_level_limit:    `ARGEN_RST_MAX_LEVEL_LIMIT,
                rate:    `ARGEN_RST_RATE,
                gain:    `ARGEN_RST_GAIN,
                en_q:    1'b0,
                st_q:    1'b0,
                scaled:  16'h0000,
                prdata:  32'h0000_0000,
                pready:  1'b0,
                pslverr: 1'b0};
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign scaled_output = q.scaled;
   assign current_level = q.level;
   assign prdata        = q.prdata;
   assign pready        = q.pready;
   assign pslverr       = q.pslverr;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   logic quiet;
   assign quiet = clk_en && !tick && !fall_en && !rise_st && !rise_en && !(psel && penable && q.pready);

   property p_start;
      clk_en && rise_en && q.state == argen_pkg::ARGEN_IDLE && $signed(ss_level) <= $signed(q.max_level_limit)
         |=> q.state == argen_pkg::ARGEN_START_HOLD && q.level == $past(ss_level);
   endproperty
   a_start: assert property (p_start) else $error("start level not applied");

   property p_disable;
      clk_en && fall_en && $signed(q.offset) <= $signed(q.max_level_limit)
         |=> q.level == q.offset ##1 (q.scaled == 16'h0000 || !$past(clk_en));
   endproperty
   a_disable: assert property (p_disable) else $error("disable did not force offset");

   property p_select;
      clk_en && tick && q.state == argen_pkg::ARGEN_RUN && !fall_en && !rise_st &&
      $signed(q.level) < $signed(level_select ? q.lvl2 : q.lvl1) && $signed(q.level) < $signed(q.max_level_limit)
         |=> $signed(q.level) > $signed($past(q.level));
   endproperty
   a_select: assert property (p_select) else $error("ramp not toward selected level");

   property p_max;
      q.state == argen_pkg::ARGEN_RUN && $past(clk_en) && $stable(q.max_level_limit) |-> $signed(q.level) <= $signed(q.max_level_limit);
   endproperty
   a_max: assert property (p_max) else $error("level above maximum limit");

   property p_hold;
      // A freshly lowered limit clamps the level one cycle later
      q.state == argen_pkg::ARGEN_RUN && quiet && $stable(q.max_level_limit) |=> $stable(q.level);
   endproperty
   a_hold: assert property (p_hold) else $error("level moved without tick");

   property p_decel;
      clk_en && tick && q.state == argen_pkg::ARGEN_DECEL && !fall_en && $signed(q.level) > $signed(ss_level)
         |=> $signed(q.level) < $signed($past(q.level)) && $signed(q.level) >= $signed($past(ss_level));
   endproperty
   a_decel: assert property (p_decel) else $error("decelerated stop not descending");

   property p_stop_end;
      clk_en && tick && !fall_en && q.state == argen_pkg::ARGEN_STOP_HOLD && $signed(q.offset) <= $signed(q.max_level_limit)
         |=> q.state == argen_pkg::ARGEN_LOCKED && q.level == q.offset;
   endproperty
   a_stop_end: assert property (p_stop_end) else $error("stop hold did not end at offset");

   property p_locked;
      clk_en && q.state == argen_pkg::ARGEN_LOCKED && (enable || decel_stop_request)
         |=> q.state == argen_pkg::ARGEN_LOCKED;
   endproperty
   a_locked: assert property (p_locked) else $error("restart while locked");

   property p_scaled;
      clk_en && q.gain != 16'h0000 && $signed(q.level) >= $signed(q.offset) &&
      $signed(q.level) - $signed(q.offset) < 32767
         |=> q.scaled == 16'((int'($signed($past(q.level))) - int'($signed($past(q.offset))))
                             / int'($past(q.gain)));
   endproperty
   a_scaled: assert property (p_scaled) else $error("scaled output wrong");

   c_run:    cover property (q.state == argen_pkg::ARGEN_START_HOLD ##1 q.state == argen_pkg::ARGEN_RUN);
   c_decel:  cover property (q.state == argen_pkg::ARGEN_DECEL ##1 q.state == argen_pkg::ARGEN_STOP_HOLD);
   c_unlock: cover property (q.state == argen_pkg::ARGEN_LOCKED ##1 q.state == argen_pkg::ARGEN_IDLE);

endmodule : argen_top

// *** verif/argen_ctrl_model.sv ***
// Purpose: Stand-in for the relay program logic driving the ramp controls
// Assumes: Bench commands change just after a rising edge of ref_clk
// Notes:   Outputs are registered, as same-clock program logic gives them
`timescale 1ns/1ps
module argen_ctrl_model (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic nrst,
   // Bench commands
   input  wire logic cmd_en,
   input  wire logic cmd_sel,
   input  wire logic cmd_stop,
   // Ramp control inputs
   output logic      enable,
   output logic      level_select,
   output logic      decel_stop_request
);
   // Registered so no control edge lands in the same step as a bench change
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         enable             <= 1'b0;
         level_select       <= 1'b0;
         decel_stop_request <= 1'b0;
      end else begin
         enable             <= cmd_en;
         level_select       <= cmd_sel;
         decel_stop_request <= cmd_stop;
      end
   end
endmodule : argen_ctrl_model

// *** verif/tb_analogue_ramp_generator.sv ***
// Purpose: Self-checking bench of the ramp generator
// Assumes: Short tick period; offset 100, start/stop 50, gain 2, rate 100
// Notes:   Step is rate over ten, so 10 per tick
`timescale 1ns/1ps
`include "argen_consts.svh"
module tb_analogue_ramp_generator;
   logic        ref_clk = 1'b0;
   logic        nrst    = 1'b0;
   logic        cmd_en  = 1'b0;
   logic        cmd_sel = 1'b0;
   logic        cmd_stop = 1'b0;
   logic        enable, level_select, decel_stop_request;
   logic [15:0] scaled_output;
   logic [17:0] current_level, prev_level;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err;
   logic        mon_on = 1'b0;
   logic        clk_en = 1'b1;
   int          n_errors = 0;
   int          total_checks = 0;

   always #4 ref_clk = ~ref_clk;

   argen_ctrl_model i_argen_ctrl_model (.ref_clk(ref_clk), .nrst(nrst), .cmd_en(cmd_en), .cmd_sel(cmd_sel),
      .cmd_stop(cmd_stop), .enable(enable), .level_select(level_select), .decel_stop_request(decel_stop_request));

   argen_top #(.TICK_CYCLES(8)) i_argen_top (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .enable(enable),
      .level_select(level_select), .decel_stop_request(decel_stop_request), .scaled_output(scaled_output),
      .current_level(current_level), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // A missing answer counts as a mismatch
      chk("pready", {31'h0, pready}, 32'h0000_0001);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_level(input logic [17:0] exp, input int lim);
      int n;
      n = 0;
      while (current_level !== exp && n < lim) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk("current_level", {14'h0, current_level}, {14'h0, exp});
   endtask : wait_level

   task automatic chk_state(input logic [2:0] exp);
      apb(1'b0, `ARGEN_OFS_STATUS, 32'h0);
      chk("state", {29'h0, rd[18:16]}, {29'h0, exp});
   endtask : chk_state

   // Any change during a ramp must be one step at most
   always @(posedge ref_clk) begin
      #1;
      if (mon_on && current_level !== prev_level) begin
         chk("ramp_step", {31'h0, ($signed(current_level) - $signed(prev_level)) > 10}, 32'h0);
         chk("ramp_step", {31'h0, ($signed(current_level) - $signed(prev_level)) < -10}, 32'h0);
      end
      prev_level = current_level;
   end

   task automatic t_reset();
      apb(1'b0, `ARGEN_OFS_MAX_LEVEL_LIMIT, 32'h0);
      chk("max_level_limit", rd, 32'h0000_4E20);
      apb(1'b0, `ARGEN_OFS_RATE, 32'h0);
      chk("rate", rd, 32'h0000_000A);
      apb(1'b0, `ARGEN_OFS_GAIN, 32'h0);
      chk("gain", rd, 32'h0000_0001);
      apb(1'b0, 8'h24, 32'h0);
      chk("unmapped_err", {31'h0, err}, 32'h1);
      $display("test reset done");
   endtask : t_reset

   task automatic t_ramp();
      apb(1'b1, `ARGEN_OFS_OFFSET, 32'h0000_0064);
      apb(1'b1, `ARGEN_OFS_SS_OFS, 32'h0000_0032);
      apb(1'b1, `ARGEN_OFS_LVL1, 32'h0000_012C);
      apb(1'b1, `ARGEN_OFS_LVL2, 32'h0000_00DC);
      apb(1'b1, `ARGEN_OFS_RATE, 32'h0000_0064);
      apb(1'b1, `ARGEN_OFS_GAIN, 32'h0000_0002);
      @(posedge ref_clk);
      cmd_en <= 1'b1;
      wait_level(18'h0_0096, 5);
      chk_state(3'h1);
      mon_on = 1'b1;
      wait_level(18'h0_00A0, 40);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("scaled_output", {16'h0, scaled_output}, 32'h0000_001E);
      wait_level(18'h0_012C, 400);
      $display("test ramp done");
   endtask : t_ramp

   task automatic t_sel_max_level_limit();
      @(posedge ref_clk);
      cmd_sel <= 1'b1;
      wait_level(18'h0_00DC, 400);
      apb(1'b1, `ARGEN_OFS_MAX_LEVEL_LIMIT, 32'h0000_0104);
      apb(1'b1, `ARGEN_OFS_LVL2, 32'h0000_0190);
      wait_level(18'h0_0104, 400);
      repeat (40) @(posedge ref_clk);
      #1;
      chk("level_limited", {14'h0, current_level}, 32'h0000_0104);
      $display("test select and limit done");
   endtask : t_sel_max_level_limit

   task automatic t_decel();
      @(posedge ref_clk);
      cmd_stop <= 1'b1;
      wait_level(18'h0_0096, 400);
      mon_on = 1'b0;
      chk_state(3'h4);
      wait_level(18'h0_0064, 40);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("scaled_output", {16'h0, scaled_output}, 32'h0);
      @(posedge ref_clk);
      cmd_stop <= 1'b0;
      repeat (30) @(posedge ref_clk);
      #1;
      chk("level_locked", {14'h0, current_level}, 32'h0000_0064);
      chk_state(3'h5);
      @(posedge ref_clk);
      cmd_en <= 1'b0;
      repeat (3) @(posedge ref_clk);
      cmd_en <= 1'b1;
      wait_level(18'h0_0096, 5);
      $display("test decel done");
   endtask : t_decel

   task automatic t_fall();
      wait_level(18'h0_00A0, 40);
      // Clock enable low must freeze the ramp across several tick periods
      @(posedge ref_clk);
      clk_en <= 1'b0;
      repeat (20) @(posedge ref_clk);
      #1;
      chk("level_frozen", {14'h0, current_level}, 32'h0000_00A0);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      @(posedge ref_clk);
      cmd_en <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("level_off", {14'h0, current_level}, 32'h0000_0064);
      chk("scaled_off", {16'h0, scaled_output}, 32'h0);
      $display("test enable fall done");
   endtask : t_fall

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   // Whole run is under a thousand cycles; this limit is 50000 cycles
   initial begin
      #400000;
      n_errors++;
      close_out();
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset();
      t_ramp();
      t_sel_max_level_limit();
      t_decel();
      t_fall();
      close_out();
   end
endmodule : tb_analogue_ramp_generator
